// file: hw/lgt_pkg.sv
package lgt_pkg;
  localparam int POS_W = 32;
  localparam int CFG_W = 3;
  localparam int CFG_ACTIVATE = 0;
  localparam int CFG_AXIS_TYPE = 1;
  localparam int CFG_POS_RESET = 2;
  localparam logic AXIS_ROTARY = 1'h1;
  localparam int ENC_IDX_W = 2;
  localparam logic [1:0] MOTOR_ENCODER = 2'h1;
  localparam int ADJ_W = 2;
  localparam logic [1:0] ADJ_DONE = 2'h3;
  localparam int CTRL_W = 16;
  localparam int CTRL_REQ_BIT = 13;
  localparam int OPT_W = 4;
  localparam int MEAS_OPT_BIT = 0;
  localparam int FLAG_W = 8;
  localparam int ROT_ABS_BIT = 1;
  localparam int LIN_EXT_BITS = 6;
  localparam int TOL_SHIFT = 2;
  localparam int HALF_SHIFT = 1;
  localparam int RATIO_W = 16;
  localparam int PPR_W = 16;
  localparam int FINE_W = 5;
  localparam int MT_W = 16;
  localparam int OVF_W = 8;
  localparam int DIV_CNT_W = 7;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [6:0] DIV_LAST = 7'h01;
  typedef enum {ST_WAIT, ST_RUN, ST_DIV, ST_FAULT} lgt_state_t;
endpackage

// file: hw/lgt_div_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lgt_div_if;
  logic start;
  logic [63:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quot;
  logic [31:0] rem;
  modport master (output start, output dividend, output divisor,
    input done, input quot, input rem);
  modport slave (input start, input dividend, input divisor,
    output done, output quot, output rem);
endinterface
`default_nettype wire

// file: hw/lgt_div.sv
`timescale 1ns/1ns
`default_nettype none
// Restoring divider, one quotient bit per enabled cycle
module lgt_div (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  lgt_div_if.slave dv
);
  import lgt_pkg::*;
  logic [DIV_CNT_W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [32:0] acc_reg;
  logic [63:0] q_reg;
  wire [32:0] shifted = {acc_reg[31:0], q_reg[63]};
  wire [32:0] trial = shifted - {1'b0, dv.divisor};
  wire fits = !trial[32];
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      acc_reg <= '0;
      q_reg <= '0;
    end
    else if (ce)
    begin
      done_reg <= 1'b0;
      if (dv.start)
      begin
        acc_reg <= '0;
        q_reg <= dv.dividend;
        cnt_reg <= DIV_STEPS;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        acc_reg <= fits ? trial : shifted;
        q_reg <= {q_reg[62:0], fits};
        cnt_reg <= cnt_reg - DIV_LAST;
        busy_reg <= (cnt_reg != DIV_LAST);
        done_reg <= (cnt_reg == DIV_LAST);
      end
    end
  end
  assign dv.done = done_reg;
  assign dv.quot = q_reg[31:0];
  assign dv.rem = acc_reg[31:0];
endmodule
`default_nettype wire

// file: hw/lgt_tracker.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Tracking runs only while the activation config bit is one.
// - Tracking applies only to the motor encoder, encoder one.
// - Position scaled by load gear numerator/denominator; rotary and linear.
// - Only one tracking instance may be active per motor parameter set.
// - Load position built from encoder data, ratios; output only on request.
// - Pulse, fine and virtual multiturn bit widths together at most 32.
// - Config bit one selects linear or rotary modulo axis.
// - Config bit two, replacement, set change or readjust clear stored data.
// - Enabling tracking after adjustment code 3 discards that adjustment.
// - Readjust while tracking clears load position and overflow count.
// - Virtual multiturn edits accepted only rotary, rotary-absolute, active.
// - Virtual multiturn counts load-side revolutions when gear is not one.
// - Rotary axes preset virtual multiturn to encoder multiturn; editable.
// - Load position repeats only after the virtual multiturn count.
// - Linear axes preset multiturn widened by six bits; not editable.
// - Switch-on compares stored and actual position; rebuild or fault.
// - Tolerance window presets to a quarter encoder range; reconfigurable.
// - Tracking range is mapped onto the reproducible positioning range.
// - Stored position may move at most half an encoder range.
module lgt_tracker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [lgt_pkg::CFG_W-1:0] tracking_config,
  input wire logic [lgt_pkg::ENC_IDX_W-1:0] encoder_index,
  input wire logic mds_tracking_taken,
  input wire logic [lgt_pkg::RATIO_W-1:0] load_gear_numerator,
  input wire logic [lgt_pkg::RATIO_W-1:0] load_gear_denominator,
  input wire logic [lgt_pkg::RATIO_W-1:0] measuring_gear_numerator,
  input wire logic [lgt_pkg::RATIO_W-1:0] measuring_gear_denominator,
  input wire logic [lgt_pkg::OPT_W-1:0] measuring_gear_option,
  input wire logic [lgt_pkg::FLAG_W-1:0] encoder_type_flags,
  input wire logic [lgt_pkg::PPR_W-1:0] pulses_per_revolution,
  input wire logic [lgt_pkg::FINE_W-1:0] fine_resolution_bits,
  input wire logic [lgt_pkg::MT_W-1:0] encoder_multiturn_resolution,
  input wire logic [lgt_pkg::ADJ_W-1:0] absolute_adjustment_control,
  input wire logic [lgt_pkg::CTRL_W-1:0] encoder_control_word,
  input wire logic vmt_wr_en,
  input wire logic [lgt_pkg::POS_W-1:0] vmt_wr_data,
  input wire logic tol_wr_en,
  input wire logic [lgt_pkg::POS_W-1:0] tol_wr_data,
  input wire logic enc_sample,
  input wire logic [lgt_pkg::POS_W-1:0] enc_position,
  input wire logic enc_replaced,
  input wire logic eds_changed,
  input wire logic enc_readjusted,
  input wire logic nv_valid,
  input wire logic [lgt_pkg::POS_W-1:0] nv_load_pos,
  input wire logic [lgt_pkg::OVF_W-1:0] nv_overflow,
  input wire logic [lgt_pkg::POS_W-1:0] nv_enc_pos,
  output logic [lgt_pkg::POS_W-1:0] load_position_value,
  output logic load_position_valid,
  output logic tracking_active,
  output logic tracking_window_fault,
  output logic adjustment_discard,
  output logic config_error,
  output logic [lgt_pkg::POS_W-1:0] virtual_multiturn_count,
  output logic [lgt_pkg::POS_W-1:0] switch_on_tolerance_window,
  output logic [lgt_pkg::POS_W-1:0] tracking_range,
  output logic nv_write,
  output logic nv_clear,
  output logic [lgt_pkg::POS_W-1:0] nv_load_pos_out,
  output logic [lgt_pkg::OVF_W-1:0] nv_overflow_out,
  output logic [lgt_pkg::POS_W-1:0] nv_enc_pos_out
);
  import lgt_pkg::*;

  function automatic logic [5:0] bits_for(input logic [31:0] v);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < 32; i++)
      if (((v - 32'h1) >> i) != 32'h0)
        n = 6'(i + 1);
    return n;
  endfunction

  // Shortest signed path between two positions on a circle of size r
  function automatic logic signed [33:0] wrap_diff(
    input logic [31:0] a, input logic [31:0] b, input logic [31:0] r);
    logic signed [33:0] d;
    logic signed [33:0] h;
    logic signed [33:0] rs;
    d = $signed({2'b00, a}) - $signed({2'b00, b});
    h = $signed({2'b00, r >> HALF_SHIFT});
    rs = $signed({2'b00, r});
    if (d > h)
      d = d - rs;
    else if (d < -h)
      d = d + rs;
    return d;
  endfunction

  lgt_state_t state_reg;
  logic [POS_W-1:0] load_pos_reg;
  logic [OVF_W-1:0] ovf_reg;
  logic [POS_W-1:0] last_enc_reg;
  logic signed [33:0] delta_reg;
  logic signed [32:0] rem_reg;
  logic [POS_W-1:0] vmt_reg;
  logic vmt_user_reg;
  logic [POS_W-1:0] tol_reg;
  logic tol_user_reg;
  logic axis_prev_reg;
  logic act_prev_reg;
  logic rst_prev_reg;
  logic fresh_reg;
  logic start_reg;
  logic [POS_W-1:0] lpv_reg;
  logic lpv_valid_reg;
  logic active_reg;
  logic fault_reg;
  logic discard_reg;
  logic cfg_err_reg;
  logic [POS_W-1:0] range_reg;
  logic nv_write_reg;
  logic nv_clear_reg;

  lgt_div_if dv ();
  lgt_div u_div (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .dv(dv)
  );

  wire rotary = tracking_config[CFG_AXIS_TYPE] == AXIS_ROTARY;
  wire [POS_W-1:0] per_rev =
    32'(pulses_per_revolution) << fine_resolution_bits;
  wire [63:0] enc_range_w = 64'(per_rev) * 64'(encoder_multiturn_resolution);
  wire [POS_W-1:0] enc_range = enc_range_w[31:0];
  wire [POS_W-1:0] half_range = enc_range >> HALF_SHIFT;
  wire [POS_W-1:0] lin_preset =
    32'(encoder_multiturn_resolution) << LIN_EXT_BITS;
  wire [POS_W-1:0] vmt_preset =
    rotary ? 32'(encoder_multiturn_resolution) : lin_preset;
  // Load range counts load-side revolutions whatever the gear factor
  wire [63:0] lrange_w = 64'(per_rev) * 64'(vmt_reg);
  wire [POS_W-1:0] lrange = lrange_w[31:0];
  wire [6:0] width_sum = 7'(bits_for(32'(pulses_per_revolution)))
    + 7'(fine_resolution_bits) + 7'(bits_for(vmt_reg));
  wire meas_on = measuring_gear_option[MEAS_OPT_BIT];
  wire [POS_W-1:0] num_eff = meas_on ?
    32'(load_gear_numerator) * 32'(measuring_gear_numerator)
    : 32'(load_gear_numerator);
  wire [POS_W-1:0] den_eff = meas_on ?
    32'(load_gear_denominator) * 32'(measuring_gear_denominator)
    : 32'(load_gear_denominator);
  wire width_err = (width_sum > 7'(POS_W)) || (den_eff == 32'h0);
  wire act_req = tracking_config[CFG_ACTIVATE]
    && (encoder_index == MOTOR_ENCODER)
    && !mds_tracking_taken && !width_err;
  wire act_rise = tracking_config[CFG_ACTIVATE] && !act_prev_reg;
  wire rst_rise = tracking_config[CFG_POS_RESET] && !rst_prev_reg;
  wire clr = rst_rise || enc_replaced || eds_changed
    || enc_readjusted;
  wire vmt_ok = vmt_wr_en && rotary
    && encoder_type_flags[ROT_ABS_BIT] && act_req;
  wire [POS_W-1:0] tol_clamped =
    (tol_wr_data > half_range) ? half_range : tol_wr_data;

  // Switch-on check against the stored encoder position
  wire signed [33:0] on_diff = wrap_diff(enc_position, nv_enc_pos,
    enc_range);
  wire signed [33:0] on_mag = on_diff[33] ? -on_diff : on_diff;
  wire in_window = on_mag <= $signed({2'b00, tol_reg});
  wire signed [33:0] run_diff = wrap_diff(enc_position, last_enc_reg,
    enc_range);

  // Remainder is carried so the ratio never drifts over long runs
  wire signed [67:0] num_s = 68'(delta_reg)
    * 68'($signed({1'b0, num_eff})) + 68'(rem_reg);
  wire neg = num_s[67];
  wire signed [67:0] mag = neg ? -num_s : num_s;
  wire signed [33:0] q_abs = $signed({2'b00, dv.quot});
  wire signed [33:0] q_s = neg ? -q_abs : q_abs;
  wire signed [32:0] r_abs = $signed({1'b0, dv.rem});
  wire signed [32:0] r_s = neg ? -r_abs : r_abs;
  wire signed [33:0] sum = $signed({2'b00, load_pos_reg}) + q_s;
  wire signed [33:0] lr_s = $signed({2'b00, lrange});
  wire wrap_up = sum >= lr_s;
  wire wrap_dn = sum < 34'sh0;
  wire [POS_W-1:0] pos_next = wrap_up ? 32'(sum - lr_s)
    : wrap_dn ? 32'(sum + lr_s) : 32'(sum);
  wire [OVF_W-1:0] ovf_next = wrap_up ? ovf_reg + 8'h01
    : wrap_dn ? ovf_reg - 8'h01 : ovf_reg;

  assign dv.start = start_reg;
  assign dv.dividend = mag[63:0];
  assign dv.divisor = den_eff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      vmt_reg <= '0;
      vmt_user_reg <= 1'b0;
      tol_reg <= '0;
      tol_user_reg <= 1'b0;
      axis_prev_reg <= 1'b0;
      // Seeded from the pins so a bit held across reset makes no edge
      act_prev_reg <= tracking_config[CFG_ACTIVATE];
      rst_prev_reg <= tracking_config[CFG_POS_RESET];
      range_reg <= '0;
      cfg_err_reg <= 1'b0;
      discard_reg <= 1'b0;
    end
    else if (ce)
    begin
      axis_prev_reg <= rotary;
      act_prev_reg <= tracking_config[CFG_ACTIVATE];
      rst_prev_reg <= tracking_config[CFG_POS_RESET];
      range_reg <= lrange;
      cfg_err_reg <= width_err;
      discard_reg <= act_rise
        && (absolute_adjustment_control == ADJ_DONE);
      if (vmt_ok)
        vmt_reg <= vmt_wr_data;
      else if (!vmt_user_reg || !rotary)
        vmt_reg <= vmt_preset;
      vmt_user_reg <= rotary && (rotary == axis_prev_reg)
        && (vmt_user_reg || vmt_ok);
      if (tol_wr_en)
        tol_reg <= tol_clamped;
      else if (!tol_user_reg)
        tol_reg <= enc_range >> TOL_SHIFT;
      tol_user_reg <= tol_user_reg || tol_wr_en;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_WAIT;
      load_pos_reg <= '0;
      ovf_reg <= '0;
      last_enc_reg <= '0;
      delta_reg <= '0;
      rem_reg <= '0;
      fresh_reg <= 1'b0;
      start_reg <= 1'b0;
      fault_reg <= 1'b0;
      nv_write_reg <= 1'b0;
      nv_clear_reg <= 1'b0;
    end
    else if (ce)
    begin
      start_reg <= 1'b0;
      nv_write_reg <= 1'b0;
      nv_clear_reg <= clr;
      if (clr)
      begin
        load_pos_reg <= '0;
        ovf_reg <= '0;
        rem_reg <= '0;
        fresh_reg <= 1'b1;
        fault_reg <= 1'b0;
        state_reg <= ST_WAIT;
      end
      else
      begin
        case (state_reg)
          ST_WAIT:
            if (act_req && enc_sample)
            begin
              last_enc_reg <= enc_position;
              rem_reg <= '0;
              if (!nv_valid || fresh_reg)
              begin
                load_pos_reg <= '0;
                ovf_reg <= '0;
                fresh_reg <= 1'b0;
                state_reg <= ST_RUN;
              end
              else if (in_window)
              begin
                load_pos_reg <= nv_load_pos;
                ovf_reg <= nv_overflow;
                delta_reg <= on_diff;
                start_reg <= 1'b1;
                state_reg <= ST_DIV;
              end
              else
              begin
                fault_reg <= 1'b1;
                state_reg <= ST_FAULT;
              end
            end
          ST_RUN:
            if (!act_req)
              state_reg <= ST_WAIT;
            else if (enc_sample)
            begin
              delta_reg <= run_diff;
              last_enc_reg <= enc_position;
              start_reg <= 1'b1;
              state_reg <= ST_DIV;
            end
          ST_DIV:
            if (dv.done)
            begin
              load_pos_reg <= pos_next;
              ovf_reg <= ovf_next;
              rem_reg <= r_s;
              nv_write_reg <= 1'b1;
              state_reg <= ST_RUN;
            end
          default:
            state_reg <= ST_FAULT;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lpv_reg <= '0;
      lpv_valid_reg <= 1'b0;
      active_reg <= 1'b0;
    end
    else if (ce)
    begin
      lpv_valid_reg <= encoder_control_word[CTRL_REQ_BIT];
      lpv_reg <= encoder_control_word[CTRL_REQ_BIT] ? load_pos_reg : '0;
      active_reg <= act_req
        && (state_reg == ST_RUN || state_reg == ST_DIV);
    end
  end

  assign load_position_value = lpv_reg;
  assign load_position_valid = lpv_valid_reg;
  assign tracking_active = active_reg;
  assign tracking_window_fault = fault_reg;
  assign adjustment_discard = discard_reg;
  assign config_error = cfg_err_reg;
  assign virtual_multiturn_count = vmt_reg;
  assign switch_on_tolerance_window = tol_reg;
  assign tracking_range = range_reg;
  assign nv_write = nv_write_reg;
  assign nv_clear = nv_clear_reg;
  assign nv_load_pos_out = load_pos_reg;
  assign nv_overflow_out = ovf_reg;
  assign nv_enc_pos_out = last_enc_reg;

  a_activation_gate: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && !tracking_config[CFG_ACTIVATE] |=> !tracking_active)
    else $error("tracking active without activation bit");
  a_motor_encoder_only: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && encoder_index != MOTOR_ENCODER |=> !tracking_active)
    else $error("tracking active on a non-motor encoder");
  a_mds_single_use: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && mds_tracking_taken |=> !tracking_active)
    else $error("second tracking in one motor parameter set");
  a_output_on_request: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce |=> load_position_valid == $past(encoder_control_word[CTRL_REQ_BIT])
      && (load_position_valid || load_position_value == '0))
    else $error("load position shown without request");
  a_width_limit: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && width_err |=> config_error && !tracking_active)
    else $error("width overflow not refused");
  a_clear_events: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && (enc_replaced || eds_changed) |=> nv_clear
      && nv_load_pos_out == '0 && nv_overflow_out == '0)
    else $error("stored position not cleared");
  a_discard_adjust: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && act_rise && absolute_adjustment_control == ADJ_DONE
      |=> adjustment_discard)
    else $error("adjustment not discarded");
  a_linear_preset: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && !rotary |=> virtual_multiturn_count == $past(lin_preset))
    else $error("linear multiturn preset wrong");
  a_window_fault: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && state_reg == ST_WAIT && act_req && enc_sample && !clr
      && nv_valid && !fresh_reg && !in_window
      |=> tracking_window_fault)
    else $error("window miss raised no fault");
  a_tol_bound: assert property (@(posedge clk)
    disable iff (!reset_n)
    ce && tol_wr_en |=> switch_on_tolerance_window <= $past(half_range))
    else $error("tolerance window above half range");
endmodule
`default_nettype wire

// file: tb/lgt_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
// Absolute motor encoder on the load gear, sampled on demand
module lgt_enc_model (
  input wire logic clk,
  output logic enc_sample,
  output logic [31:0] enc_position
);
  initial
  begin
    enc_sample = 1'b0;
    enc_position = 32'h0;
  end
  // Callers keep moves at most half the encoder range
  // Position is only qualified by the strobe, so the inverse follows
  // to expose any late capture
  task automatic send(input logic [31:0] pos);
    @(negedge clk);
    enc_sample = 1'b1;
    enc_position = pos;
    @(negedge clk);
    enc_sample = 1'b0;
    enc_position = ~pos;
  endtask
endmodule
`default_nettype wire

// file: tb/lgt_tracker_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lgt_tracker_bench;
  import lgt_pkg::*;
  logic clk, reset_n, ce, mds_tracking_taken, vmt_wr_en, tol_wr_en;
  logic enc_sample, enc_replaced, eds_changed, enc_readjusted, nv_valid;
  logic [CFG_W-1:0] tracking_config;
  logic [ENC_IDX_W-1:0] encoder_index;
  logic [RATIO_W-1:0] load_gear_numerator, load_gear_denominator;
  logic [RATIO_W-1:0] measuring_gear_numerator, measuring_gear_denominator;
  logic [OPT_W-1:0] measuring_gear_option;
  logic [FLAG_W-1:0] encoder_type_flags;
  logic [PPR_W-1:0] pulses_per_revolution;
  logic [FINE_W-1:0] fine_resolution_bits;
  logic [MT_W-1:0] encoder_multiturn_resolution;
  logic [ADJ_W-1:0] absolute_adjustment_control;
  logic [CTRL_W-1:0] encoder_control_word;
  logic [POS_W-1:0] vmt_wr_data, tol_wr_data, enc_position, nv_load_pos;
  logic [POS_W-1:0] nv_enc_pos, load_position_value, virtual_multiturn_count;
  logic [POS_W-1:0] switch_on_tolerance_window, tracking_range;
  logic [POS_W-1:0] nv_load_pos_out, nv_enc_pos_out;
  logic [OVF_W-1:0] nv_overflow, nv_overflow_out;
  logic load_position_valid, tracking_active, tracking_window_fault;
  logic adjustment_discard, config_error, nv_write, nv_clear;
  int mismatches = 0;
  int compares = 0;

  lgt_tracker i_dut (.clk, .reset_n, .ce, .tracking_config, .encoder_index,
    .mds_tracking_taken, .load_gear_numerator, .load_gear_denominator,
    .measuring_gear_numerator, .measuring_gear_denominator,
    .measuring_gear_option, .encoder_type_flags, .pulses_per_revolution,
    .fine_resolution_bits, .encoder_multiturn_resolution,
    .absolute_adjustment_control, .encoder_control_word, .vmt_wr_en,
    .vmt_wr_data, .tol_wr_en, .tol_wr_data, .enc_sample, .enc_position,
    .enc_replaced, .eds_changed, .enc_readjusted, .nv_valid, .nv_load_pos,
    .nv_overflow, .nv_enc_pos, .load_position_value, .load_position_valid,
    .tracking_active, .tracking_window_fault, .adjustment_discard,
    .config_error, .virtual_multiturn_count, .switch_on_tolerance_window,
    .tracking_range, .nv_write, .nv_clear, .nv_load_pos_out,
    .nv_overflow_out, .nv_enc_pos_out);
  lgt_enc_model i_enc (.clk(clk), .enc_sample(enc_sample),
    .enc_position(enc_position));

  always #5 clk = ~clk;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded watch of a one-cycle pulse or a flag
  task automatic seen(input int sel, input int n, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (n)
    begin
      @(negedge clk);
      case (sel)
        0: hit |= adjustment_discard;
        1: hit |= nv_write;
        2: hit |= nv_clear;
        default: hit |= tracking_window_fault;
      endcase
    end
    chk1(hit, exp);
  endtask
  task automatic wr(input logic vmt, input logic [31:0] d);
    @(negedge clk);
    vmt_wr_en = vmt;
    tol_wr_en = !vmt;
    vmt_wr_data = d;
    tol_wr_data = d;
    @(negedge clk);
    vmt_wr_en = 1'b0;
    tol_wr_en = 1'b0;
  endtask
  task automatic restart(input logic [2:0] cfg);
    @(negedge clk);
    reset_n = 1'b0;
    tracking_config = cfg;
    cyc(4);
    reset_n = 1'b1;
    cyc(2);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    test_done();
  end

  initial
  begin
    clk = 1'b0; reset_n = 1'b0; ce = 1'b1; tracking_config = 3'h2;
    encoder_index = 2'h1; mds_tracking_taken = 1'b0;
    load_gear_numerator = 16'h0003; load_gear_denominator = 16'h0001;
    measuring_gear_numerator = 16'h0002; measuring_gear_denominator = 16'h0001;
    measuring_gear_option = 4'h1; encoder_type_flags = 8'h02;
    // Per revolution 4096, range 8 turns: well inside 32 bits
    pulses_per_revolution = 16'h0400; fine_resolution_bits = 5'h02;
    encoder_multiturn_resolution = 16'h0008;
    absolute_adjustment_control = 2'h3; encoder_control_word = 16'h0000;
    vmt_wr_en = 1'b0; tol_wr_en = 1'b0; vmt_wr_data = 32'h0;
    tol_wr_data = 32'h0; enc_replaced = 1'b0; eds_changed = 1'b0;
    enc_readjusted = 1'b0; nv_valid = 1'b0; nv_load_pos = 32'h0;
    nv_overflow = 8'h00; nv_enc_pos = 32'h0;
    cyc(4);
    chk32(virtual_multiturn_count, 32'h0);
    reset_n = 1'b1;
    cyc(2);
    chk32(virtual_multiturn_count, 32'h8);
    chk32(switch_on_tolerance_window, 32'h2000);
    wr(1'b1, 32'h5);
    cyc(1);
    chk32(virtual_multiturn_count, 32'h8);
    $display("presets done");
    @(negedge clk);
    tracking_config = 3'h3;
    seen(0, 3, 1'b1);
    wr(1'b1, 32'h5);
    chk32(virtual_multiturn_count, 32'h5);
    cyc(1);
    chk32(tracking_range, 32'h5000);
    wr(1'b0, 32'h100);
    chk32(switch_on_tolerance_window, 32'h100);
    wr(1'b0, 32'h7FFF0000);
    chk32(switch_on_tolerance_window, 32'h4000);
    $display("edits done");
    i_enc.send(32'h100);
    cyc(3);
    chk1(tracking_active, 1'b1);
    // Each move of 0x800 increments scales by gear 3 and measuring gear 2
    i_enc.send(32'h900);
    seen(1, 80, 1'b1);
    chk32(load_position_value, 32'h0);
    // Second move passes the five-turn load range and wraps once
    i_enc.send(32'h1100);
    seen(1, 80, 1'b1);
    encoder_control_word = 16'h2000;
    cyc(2);
    chk1(load_position_valid, 1'b1);
    chk32(load_position_value, 32'h1000);
    chk32({24'h0, nv_overflow_out}, 32'h1);
    chk32(nv_enc_pos_out, 32'h1100);
    encoder_control_word = 16'h0000;
    encoder_index = 2'h2;
    cyc(3);
    chk1(tracking_active, 1'b0);
    encoder_index = 2'h1;
    mds_tracking_taken = 1'b1;
    i_enc.send(32'h1900);
    cyc(3);
    chk1(tracking_active, 1'b0);
    mds_tracking_taken = 1'b0;
    $display("tracking done");
    for (int e = 0; e < 4; e++)
    begin
      @(negedge clk);
      enc_replaced = (e == 0);
      eds_changed = (e == 1);
      enc_readjusted = (e == 2);
      tracking_config = (e == 3) ? 3'h7 : 3'h3;
      @(negedge clk);
      {enc_replaced, eds_changed, enc_readjusted} = 3'h0;
      tracking_config = 3'h3;
      chk1(nv_clear, 1'b1);
      chk32(nv_load_pos_out, 32'h0);
      chk32({24'h0, nv_overflow_out}, 32'h0);
    end
    restart(3'h1);
    chk32(virtual_multiturn_count, 32'h200);
    wr(1'b1, 32'h5);
    chk32(virtual_multiturn_count, 32'h200);
    $display("clear and linear done");
    nv_valid = 1'b1;
    nv_enc_pos = 32'h100;
    nv_load_pos = 32'h1000;
    nv_overflow = 8'h02;
    restart(3'h3);
    i_enc.send(32'h180);
    seen(3, 4, 1'b0);
    seen(1, 80, 1'b1);
    // Stored 0x1000 plus 0x80 increments scaled by six
    chk32(nv_load_pos_out, 32'h1300);
    chk32({24'h0, nv_overflow_out}, 32'h2);
    restart(3'h3);
    i_enc.send(32'h4100);
    seen(3, 4, 1'b1);
    @(negedge clk);
    tracking_config = 3'h7;
    seen(2, 2, 1'b1);
    chk1(tracking_window_fault, 1'b0);
    $display("switch-on done");
    fine_resolution_bits = 5'h1F;
    cyc(3);
    chk1(config_error, 1'b1);
    fine_resolution_bits = 5'h02;
    load_gear_denominator = 16'h0000;
    cyc(3);
    chk1(config_error, 1'b1);
    // With the enable low an edit must not land
    ce = 1'b0;
    wr(1'b0, 32'h100);
    chk32(switch_on_tolerance_window, 32'h2000);
    ce = 1'b1;
    $display("config checks done");
    test_done();
  end
endmodule
`default_nettype wire
